// >>> logic/smbus_cfg.svh
// Constants of the serial command port: address, field sizes, timing.
`ifndef SMBUS_CFG_SVH
`define SMBUS_CFG_SVH

`define SMB_SLAVE_ADDR 7'h20
`define SMB_BITS_PER_BYTE 4'h8
`define SMB_SYNC_RESET 1'b1
`define SMB_TIMEOUT_MS 35
`define SMB_CORE_CLK_KHZ 25000
`define SMB_TIMEOUT_CYCLES (`SMB_TIMEOUT_MS * `SMB_CORE_CLK_KHZ)

`endif

// >>> logic/smbus_pkg.sv
// Types shared by the serial command port.
package smbus_pkg;

    // Protocol phase of the slave
    typedef enum logic [1:0] {
        st_idle,
        st_addr,
        st_rx,
        st_tx
    } smb_state_t;

endpackage

// >>> logic/smbus_slave_command_port.sv
// Serial management bus slave: address decode, pointer, byte transfers.
`timescale 1ns/1ps
`include "smbus_cfg.svh"

module smbus_slave_command_port
    import smbus_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `SMB_TIMEOUT_CYCLES
) (
    input wire logic core_clk, // Core clock, 25 MHz
    input wire logic reset, // Synchronous reset, high
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic scl_in, // Bus clock pin level
    input wire logic sda_in, // Bus data pin level
    output logic sda_out, // Data drive value, always low
    output logic sda_oe, // High while pulling data low
    input wire logic bus_timeout_enable_bit, // Timeout enable
    output logic [7:0] cmd_code, // Address pointer
    output logic [7:0] wr_data, // Received data byte
    output logic [7:0] wr_index, // Data byte number, 0 first
    output logic wr_strobe, // One-cycle pulse per data byte
    output logic [7:0] rd_index, // Byte number the master reads next
    input wire logic [7:0] rd_data, // Read byte for rd_index
    output logic fault_clear, // One-cycle pulse on send byte
    output logic timeout_event, // One-cycle pulse on bus timeout
    output logic busy // High from a start until stop, timeout, foreign address or master nack
);

    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

    smb_state_t state_q;
    logic [1:0] pins_s;
    logic scl_s, sda_s, scl_prev_q, sda_prev_q;
    logic scl_rise, scl_fall, start_cond, stop_cond, activity;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic in_ack_q, master_ack_q;
    logic [7:0] rx_cnt_q;
    logic [TW-1:0] idle_cnt_q;
    logic timed_out;

    // Sign-extension free increment of a byte counter
    function automatic logic [7:0] inc8(input logic [7:0] v);
        inc8 = v + 8'h01;
    endfunction

    // =====================================
    // Pin sampling
    smbus_sync #(
        .W(2)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .ce(ce),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    assign sda_out = 1'b0;
    assign busy = (state_q != st_idle);

    // Previous synchronised levels for edge finding
    always_ff @(posedge core_clk) begin
        if (reset) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (ce) begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // Data moving while clock is high marks start or stop
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign activity = (scl_s ^ scl_prev_q) | (sda_s ^ sda_prev_q);

    // =====================================
    // Bus idle timeout
    // Counts only while busy, address bytes included, so an idle bus never fires it.
    assign timed_out = bus_timeout_enable_bit && busy
        && (idle_cnt_q >= TW'(TIMEOUT_CYCLES - 1));

    always_ff @(posedge core_clk) begin
        if (reset) begin
            idle_cnt_q <= '0;
        end else if (ce) begin
            if (activity || !busy || !bus_timeout_enable_bit) begin
                idle_cnt_q <= '0;
            end else if (!timed_out) begin
                idle_cnt_q <= idle_cnt_q + TW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            timeout_event <= 1'b0;
        end else if (ce) begin
            timeout_event <= timed_out && !activity;
        end
    end

    // =====================================
    // Bit shifter and bit counter, sampled on clock rise
    // One shifter serves both directions: in a read the shifted-in
    // bits are the device's own echo and are never used.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            master_ack_q <= 1'b0;
        end else if (ce) begin
            if (start_cond || timed_out) begin
                bit_cnt_q <= 4'h0;
            end else if (scl_fall && in_ack_q
                && (state_q == st_tx || state_q == st_addr)) begin
                // Read address ack ends here too: first byte loads now
                shift_q <= rd_data;
            end else if (scl_rise && state_q != st_idle) begin
                if (bit_cnt_q == `SMB_BITS_PER_BYTE) begin
                    bit_cnt_q <= 4'h0;
                    master_ack_q <= ~sda_s;
                end else begin
                    shift_q <= {shift_q[6:0], sda_s};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
            end
        end
    end

    // =====================================
    // Protocol state, ack phase and data drive, changed on clock fall
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= st_idle;
            in_ack_q <= 1'b0;
            sda_oe <= 1'b0;
        end else if (ce) begin
            if (timed_out) begin
                state_q <= st_idle;
                in_ack_q <= 1'b0;
                sda_oe <= 1'b0;
            end else if (start_cond) begin
                state_q <= st_addr;
                in_ack_q <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                state_q <= st_idle;
                in_ack_q <= 1'b0;
                sda_oe <= 1'b0;
            end else if (scl_fall && state_q != st_idle) begin
                if (in_ack_q) begin
                    // Ninth clock over: release or send next byte
                    in_ack_q <= 1'b0;
                    case (state_q)
                        st_addr: begin
                            state_q <= shift_q[0] ? st_tx : st_rx;
                            sda_oe <= shift_q[0] & ~rd_data[7];
                        end
                        st_tx: begin
                            if (master_ack_q) begin
                                sda_oe <= ~rd_data[7];
                            end else begin
                                state_q <= st_idle;
                                sda_oe <= 1'b0;
                            end
                        end
                        default: begin
                            sda_oe <= 1'b0;
                        end
                    endcase
                end else if (bit_cnt_q == `SMB_BITS_PER_BYTE) begin
                    in_ack_q <= 1'b1;
                    case (state_q)
                        st_addr: begin
                            if (shift_q[7:1] == `SMB_SLAVE_ADDR) begin
                                sda_oe <= 1'b1;
                            end else begin
                                state_q <= st_idle;
                                in_ack_q <= 1'b0;
                                sda_oe <= 1'b0;
                            end
                        end
                        st_rx: begin
                            sda_oe <= 1'b1;
                        end
                        default: begin
                            sda_oe <= 1'b0;
                        end
                    endcase
                end else if (state_q == st_tx) begin
                    sda_oe <= ~shift_q[7];
                end
            end
        end
    end

    // =====================================
    // Write path: pointer, data strobes and fault clear
    // The pointer is kept across a repeated start for the read.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmd_code <= 8'h00;
            wr_data <= 8'h00;
            wr_index <= 8'h00;
            wr_strobe <= 1'b0;
            rx_cnt_q <= 8'h00;
            fault_clear <= 1'b0;
        end else if (ce) begin
            wr_strobe <= 1'b0;
            fault_clear <= 1'b0;
            if (start_cond) begin
                rx_cnt_q <= 8'h00;
            end else if (stop_cond && state_q == st_rx) begin
                fault_clear <= (rx_cnt_q == 8'h01);
            end else if (scl_fall && !in_ack_q && state_q == st_rx
                && bit_cnt_q == `SMB_BITS_PER_BYTE) begin
                rx_cnt_q <= inc8(rx_cnt_q);
                if (rx_cnt_q == 8'h00) begin
                    cmd_code <= shift_q;
                end else begin
                    wr_data <= shift_q;
                    wr_index <= rx_cnt_q - 8'h01;
                    wr_strobe <= 1'b1;
                end
            end
        end
    end

    // =====================================
    // Read path: index of the byte the master fetches next
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_index <= 8'h00;
        end else if (ce) begin
            if (start_cond) begin
                rd_index <= 8'h00;
            end else if (scl_rise && in_ack_q && state_q == st_tx
                && !sda_s) begin
                // Step on the ack rise so rd_data has settled by the fall
                rd_index <= inc8(rd_index);
            end
        end
    end

endmodule

// >>> logic/smbus_sync.sv
// Two-flop synchroniser for the bus pins.
`timescale 1ns/1ps
`include "smbus_cfg.svh"

module smbus_sync #(
    parameter int W = 2
) (
    input wire logic core_clk, // Core clock
    input wire logic reset, // Synchronous reset, high
    input wire logic ce, // Clock enable
    input wire logic [W-1:0] async_in, // Raw pin levels
    output logic [W-1:0] sync_out // Levels in core domain
);

    logic [W-1:0] meta_q;

    // =====================================
    // Synchroniser stages
    // Only the second stage is seen by other logic.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_q <= {W{`SMB_SYNC_RESET}};
            sync_out <= {W{`SMB_SYNC_RESET}};
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// >>> tb/smb_host.sv
// Behavioural bus host that clocks frames onto the link.
`timescale 1ns/1ps
module smb_host (
    output logic scl, // Bus clock
    output logic pull, // High while host pulls data low
    input wire logic sda // Resolved data line
);
    localparam time Q = 80;
    // ==============================
    // Clock idles high and stands still between frames
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // Start or repeated start: data falls while clock is high
    task automatic start();
        if (scl == 1'b0) begin
            pull = 1'b0;
            #Q scl = 1'b1;
            #Q;
        end
        pull = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask
    // Stop: data low in the low half, rises while clock is high
    task automatic stop();
        pull = 1'b1;
        #Q scl = 1'b1;
        #Q pull = 1'b0;
        #Q;
    endtask
    // Nine pulses MSB first; set in low half, read late in high half
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack);
        logic [8:0] v;
        logic [8:0] r;
        v = {d, ack_in};
        for (int i = 8; i >= 0; i--) begin
            pull = !v[i];
            #Q scl = 1'b1;
            #(2 * Q) r[i] = sda;
            scl = 1'b0;
            #Q;
        end
        q = r[8:1];
        ack = r[0];
    endtask
endmodule

// >>> tb/smbus_port_checker.sv
// Assertion checker for the serial command port pins and pulses.
`timescale 1ns/1ps
module smbus_port_checker #(
    parameter int TIMEOUT_CYCLES = 200
) (
    input wire logic core_clk, // Clock
    input wire logic reset, // Reset
    input wire logic scl_in, // Bus clock
    input wire logic sda_in, // Bus data
    input wire logic sda_oe, // Data pull
    input wire logic bus_timeout_enable_bit, // Timeout on
    input wire logic wr_strobe, // Byte pulse
    input wire logic fault_clear, // Clear pulse
    input wire logic timeout_event, // Abort pulse
    input wire logic busy // Addressed
);
    logic [15:0] quiet_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // ==============================
    // Quiet span on the pins; saturates so a long idle never wraps
    always_ff @(posedge core_clk) begin
        if (reset || $changed(scl_in) || $changed(sda_in)) begin
            quiet_q <= 16'h0;
        end else if (quiet_q != 16'hffff) begin
            quiet_q <= quiet_q + 16'h1;
        end
    end
    property p_oe_busy; sda_oe |-> busy; endproperty
    a_oe_busy: assert property (p_oe_busy) else $error("pull idle");
    property p_oe_low; $changed(sda_oe) |-> !$past(scl_in, 2); endproperty
    a_oe_low: assert property (p_oe_low) else $error("pull moved");
    property p_oe_hold;
        scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pull unstable");
    property p_ack; wr_strobe |-> ##[0:2] sda_oe; endproperty
    a_ack: assert property (p_ack) else $error("byte not acked");
    property p_clr; fault_clear |-> !busy; endproperty
    a_clr: assert property (p_clr) else $error("clear while busy");
    property p_to_gate; timeout_event |-> $past(bus_timeout_enable_bit);
    endproperty
    a_to_gate: assert property (p_to_gate) else $error("timeout off");
    property p_to_early; timeout_event |-> quiet_q >= TIMEOUT_CYCLES - 8;
    endproperty
    a_to_early: assert property (p_to_early) else $error("early");
    property p_to_late;
        bus_timeout_enable_bit && quiet_q > TIMEOUT_CYCLES + 8 |-> !busy;
    endproperty
    a_to_late: assert property (p_to_late) else $error("no timeout");
endmodule
bind smbus_slave_command_port smbus_port_checker
    #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.core_clk(core_clk),
    .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
    .bus_timeout_enable_bit(bus_timeout_enable_bit),
    .wr_strobe(wr_strobe), .fault_clear(fault_clear),
    .timeout_event(timeout_event), .busy(busy));

// >>> tb/smbus_slave_command_port_bench.sv
// Self-checking bench for the serial command port with a host model.
`timescale 1ns/1ps
module smbus_slave_command_port_bench;
    localparam int TMO = 200;
    logic core_clk = 1'b0, reset = 1'b1, toe = 1'b0;
    logic scl, pull, sda_out, sda_oe, wr_strobe, fault_clear, busy;
    logic timeout_event;
    logic [7:0] cmd_code, wr_data, wr_index, rd_index, base = 8'h0;
    logic [15:0] exp_q[$];
    logic [15:0] want;
    int fails = 0, n_tests = 0, n_fc = 0, n_to = 0;
    // Open-drain data line with pull-up
    wire sda = !((sda_oe && !sda_out) || pull);
    always #20 core_clk = ~core_clk;
    smb_host host (.scl(scl), .pull(pull), .sda(sda));
    smbus_slave_command_port #(.TIMEOUT_CYCLES(TMO)) dut (
        .core_clk(core_clk), .reset(reset), .ce(1'b1), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .bus_timeout_enable_bit(toe), .cmd_code(cmd_code),
        .wr_data(wr_data), .wr_index(wr_index), .wr_strobe(wr_strobe),
        .rd_index(rd_index), .rd_data(rd_index + base),
        .fault_clear(fault_clear), .timeout_event(timeout_event),
        .busy(busy));
    // ==============================
    // Comparison and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("BAD at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watcher: each data byte pops the oldest note; pulses counted
    always @(negedge core_clk) begin
        if (wr_strobe === 1'b1) begin
            want = exp_q.size() != 0 ? exp_q.pop_front() : 16'hxxxx;
            check({wr_index, wr_data}, want);
        end
        n_fc += int'(fault_clear === 1'b1);
        n_to += int'(timeout_event === 1'b1);
    end
    // Pointer write, then n bytes written, or read after repeated start
    task automatic op(input logic [7:0] cmd, input int n, input logic rd);
        logic [7:0] q, d;
        logic a;
        host.start();
        host.xfer(8'h40, 1'b1, q, a);
        check(16'(a), 16'h0);
        host.xfer(cmd, 1'b1, q, a);
        check(16'(a), 16'h0);
        if (rd) begin
            host.start();
            host.xfer(8'h41, 1'b1, q, a);
            check(16'(a), 16'h0);
        end
        for (int i = 0; i < n; i++) begin
            d = (i == 0 && n > 2) ? 8'(n - 1) : 8'($urandom);
            if (!rd) exp_q.push_back({8'(i), d});
            host.xfer(rd ? 8'hff : d, !rd || i == n - 1, q, a);
            check(16'(rd ? q : a),
                16'(rd ? base + 8'(i) : 8'h0));
        end
        host.stop();
        repeat (8) @(posedge core_clk);
        #1;
        check(16'(cmd_code), 16'(cmd));
    endtask
    // Main sequence: transfers, foreign addresses, timeout on and off
    initial begin
        int ns[7] = '{0, 1, 2, 4, 1, 2, 4};
        logic [7:0] q;
        logic [6:0] ad;
        logic a;
        void'($urandom(86));
        base = 8'($urandom);
        repeat (12) @(posedge core_clk);
        #1 reset = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        foreach (ns[k]) op(8'($urandom), ns[k], k > 3);
        $display("transfer tests done");
        repeat (4) begin
            ad = 7'($urandom);
            ad = (ad == 7'h20) ? 7'h5f : ad;
            host.start();
            host.xfer({ad, 1'($urandom)}, 1'b1, q, a);
            check(16'(a), 16'h1);
            host.xfer(8'($urandom), 1'b1, q, a);
            check(16'({a, busy}), 16'h2);
            host.stop();
        end
        $display("foreign address test done");
        @(posedge core_clk);
        #1 toe = 1'b1;
        for (int k = 0; k < 2; k++) begin
            host.start();
            host.xfer(8'h40, 1'b1, q, a);
            repeat (TMO + 40) @(posedge core_clk);
            #1;
            check(16'({busy, sda_oe}), 16'(k * 2));
            host.stop();
            @(posedge core_clk);
            #1 toe = 1'b0;
        end
        check(16'(n_to), 16'h1);
        check(16'(n_fc), 16'h1);
        check(16'(exp_q.size()), 16'h0);
        $display("timeout test done");
        close_out();
    end
    // Watchdog, several times the expected run
    initial begin
        #(40 * 30000);
        fails++;
        close_out();
    end
endmodule
